// ===== src/ghlt_map.svh
// Register offsets, field positions, reset values and timing counts of the GPIO
// hotkey and level translator block. Included by the block's package users only.
`ifndef GHLT_MAP_SVH
`define GHLT_MAP_SVH

// ----------------------------------------------------------------------------
// Register offsets (byte addresses on the register port)
// ----------------------------------------------------------------------------
`define GHLT_OFS_SET_MSB     8'h02
`define GHLT_OFS_SET_LSB     8'h03
`define GHLT_OFS_CLR_MSB     8'h04
`define GHLT_OFS_CLR_LSB     8'h05
`define GHLT_OFS_MON_MSB     8'h06
`define GHLT_OFS_MON_LSB     8'h07
`define GHLT_OFS_DIR_MSB     8'h08
`define GHLT_OFS_DIR_LSB     8'h09
`define GHLT_OFS_EDS_MSB     8'h0a
`define GHLT_OFS_EDS_LSB     8'h0b
`define GHLT_OFS_RISE_MSB    8'h0c
`define GHLT_OFS_RISE_LSB    8'h0d
`define GHLT_OFS_FALL_MSB    8'h0e
`define GHLT_OFS_FALL_LSB    8'h0f
`define GHLT_OFS_PULL_MSB    8'h10
`define GHLT_OFS_PULL_LSB    8'h11
`define GHLT_OFS_AFU_MSB     8'h12
`define GHLT_OFS_AFU_LSB     8'h13
`define GHLT_OFS_AFL_MSB     8'h14
`define GHLT_OFS_AFL_LSB     8'h15
`define GHLT_OFS_LT_EN       8'h16
`define GHLT_OFS_LT_DIR      8'h17
`define GHLT_OFS_SYS_CTRL    8'h20
`define GHLT_OFS_IMSK_MSB    8'h21
`define GHLT_OFS_IMSK_LSB    8'h22

// ----------------------------------------------------------------------------
// Field positions and codes
// ----------------------------------------------------------------------------
`define GHLT_SYS_SLEEP_BIT   0
`define GHLT_SYS_GIE_BIT     1
`define GHLT_FUNC_PRIMARY    2'b00
`define GHLT_FUNC_ALT1       2'b01
`define GHLT_FUNC_ALT2       2'b10
`define GHLT_FUNC_RSVD       2'b11

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define GHLT_RST_PINS        16'h0000
`define GHLT_RST_FUNC        32'h0000_0000
`define GHLT_RST_BYTE        8'h00

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define GHLT_MCLK_HZ         25000000
`define GHLT_RUNCLK_HZ       4000000
`define GHLT_SLPCLK_HZ       32768
`define GHLT_MIN_PULSE_NS    62500
`define GHLT_RUN_DIV_CYC     (`GHLT_MCLK_HZ / `GHLT_RUNCLK_HZ)
`define GHLT_SLP_DIV_CYC     (`GHLT_MCLK_HZ / `GHLT_SLPCLK_HZ)
`define GHLT_MIN_PULSE_CYC   ((`GHLT_MIN_PULSE_NS * 25 + 999) / 1000)

`endif

// ===== src/ghlt_pkg.sv
// Types shared by the GPIO hotkey and level translator block.
// Assumes the map header is included by every file that needs numbers.
package ghlt_pkg;

    // ------------------------------------------------------------------------
    // Power mode of the expander core
    // ------------------------------------------------------------------------
    typedef enum logic {
        GHLT_RUN,
        GHLT_SLEEP
    } ghlt_mode_t;

    typedef logic [15:0] ghlt_pins_t;

endpackage

// ===== src/ghlt_pin_sync.sv
// One pin's input path: two-stage synchroniser, rate sampler and edge finder.
// Assumes sampleTick is a one-cycle pulse from the same clock.
module ghlt_pin_sync
    import ghlt_pkg::*;
(
    input  wire logic mclk,
    input  wire logic resetn,
    input  wire logic pinLevel,
    input  wire logic sampleTick,
    output logic      syncLevel,
    output logic      riseEvt,
    output logic      fallEvt
);
    logic metaLevel;
    logic sampled;

    // ------------------------------------------------------------------------
    // Synchroniser; the first stage feeds the second stage only.
    // ------------------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            metaLevel <= 1'b0;
            syncLevel <= 1'b0;
        end else begin
            metaLevel <= pinLevel;
            syncLevel <= metaLevel;
        end
    end

    // Sampling at the active clock rate can miss glitches shorter than a tick,
    // which is why only pulses of the minimum width are guaranteed.
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            sampled <= 1'b0;
            riseEvt <= 1'b0;
            fallEvt <= 1'b0;
        end else begin
            riseEvt <= sampleTick & syncLevel & ~sampled;
            fallEvt <= sampleTick & ~syncLevel & sampled;
            if (sampleTick) begin
                sampled <= syncLevel;
            end
        end
    end

endmodule

// ===== src/ghlt_gpio_top.sv
// GPIO controller slice: pin state, direction, edge status, function select,
// hotkey wake from sleep and the eight-channel level translator.
// Assumes a byte-wide register port driven by the serial interface logic on mclk,
// and pins that come from outside the clock domain.
`include "ghlt_map.svh"

module ghlt_gpio_top
    import ghlt_pkg::*;
#(
    parameter int NPINS     = 16,
    parameter int RUN_DIV   = `GHLT_RUN_DIV_CYC,
    parameter int SLEEP_DIV = `GHLT_SLP_DIV_CYC
)
(
    input  wire logic        mclk,
    input  wire logic        resetn,
    input  wire logic [7:0]  regAddr,
    input  wire logic [7:0]  regWrData,
    input  wire logic        regWrite,
    input  wire logic        regRead,
    output logic      [7:0]  regRdData,
    input  wire logic [15:0] pinIn,
    output logic      [15:0] pinOut,
    output logic      [15:0] pinOe,
    output logic      [15:0] pullUpEn,
    output logic      [31:0] funcSel,
    output logic      [15:0] gpioIrq,
    output logic             wakeUp,
    output logic             sleepMode
);

    // ------------------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------------------
    if (NPINS != 16) begin : g_bad_pins
        $error("ghlt_gpio_top supports exactly 16 pins");
    end
    if (RUN_DIV < 1 || SLEEP_DIV < 1 || SLEEP_DIV > 65535) begin : g_bad_div
        $error("ghlt_gpio_top divider out of range");
    end
    if (2 * SLEEP_DIV > `GHLT_MIN_PULSE_CYC) begin : g_bad_pulse
        $error("ghlt_gpio_top sleep sampling too slow for minimum pulse");
    end

    // ------------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------------
    ghlt_mode_t  modeState;
    ghlt_pins_t  outState;
    ghlt_pins_t  dirReg;
    ghlt_pins_t  edgeStatus;
    ghlt_pins_t  riseEn;
    ghlt_pins_t  fallEn;
    ghlt_pins_t  pinIrqMask;
    logic [7:0]  ltEn;
    logic [7:0]  ltDir;
    logic        globalIrqEn;
    logic [15:0] tickCount;

    ghlt_pins_t  syncLevel;
    ghlt_pins_t  riseEvt;
    ghlt_pins_t  fallEvt;

    // ------------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------------
    wire wrSetHi  = regWrite && regAddr == `GHLT_OFS_SET_MSB;
    wire wrSetLo  = regWrite && regAddr == `GHLT_OFS_SET_LSB;
    wire wrClrHi  = regWrite && regAddr == `GHLT_OFS_CLR_MSB;
    wire wrClrLo  = regWrite && regAddr == `GHLT_OFS_CLR_LSB;
    wire wrDirHi  = regWrite && regAddr == `GHLT_OFS_DIR_MSB;
    wire wrDirLo  = regWrite && regAddr == `GHLT_OFS_DIR_LSB;
    wire wrEdsHi  = regWrite && regAddr == `GHLT_OFS_EDS_MSB;
    wire wrEdsLo  = regWrite && regAddr == `GHLT_OFS_EDS_LSB;
    wire wrRiseHi = regWrite && regAddr == `GHLT_OFS_RISE_MSB;
    wire wrRiseLo = regWrite && regAddr == `GHLT_OFS_RISE_LSB;
    wire wrFallHi = regWrite && regAddr == `GHLT_OFS_FALL_MSB;
    wire wrFallLo = regWrite && regAddr == `GHLT_OFS_FALL_LSB;
    wire wrPullHi = regWrite && regAddr == `GHLT_OFS_PULL_MSB;
    wire wrPullLo = regWrite && regAddr == `GHLT_OFS_PULL_LSB;
    wire wrAfuHi  = regWrite && regAddr == `GHLT_OFS_AFU_MSB;
    wire wrAfuLo  = regWrite && regAddr == `GHLT_OFS_AFU_LSB;
    wire wrAflHi  = regWrite && regAddr == `GHLT_OFS_AFL_MSB;
    wire wrAflLo  = regWrite && regAddr == `GHLT_OFS_AFL_LSB;
    wire wrLtEn   = regWrite && regAddr == `GHLT_OFS_LT_EN;
    wire wrLtDir  = regWrite && regAddr == `GHLT_OFS_LT_DIR;
    wire wrSys    = regWrite && regAddr == `GHLT_OFS_SYS_CTRL;
    wire wrMskHi  = regWrite && regAddr == `GHLT_OFS_IMSK_MSB;
    wire wrMskLo  = regWrite && regAddr == `GHLT_OFS_IMSK_LSB;

    // Byte strobes widened to pin masks; the high byte always serves pins 15..8.
    wire [15:0] setMask = {wrSetHi ? regWrData : 8'h00, wrSetLo ? regWrData : 8'h00};
    wire [15:0] clrMask = {wrClrHi ? regWrData : 8'h00, wrClrLo ? regWrData : 8'h00};
    wire [15:0] edsMask = {wrEdsHi ? regWrData : 8'h00, wrEdsLo ? regWrData : 8'h00};
    wire [15:0] ltLock  = {ltEn, ltEn};

    // ------------------------------------------------------------------------
    // Sample tick: run-rate or sleep-rate, following the power mode.
    // ------------------------------------------------------------------------
    wire [15:0] tickLimit  = (modeState == GHLT_SLEEP) ? 16'(SLEEP_DIV - 1)
                                                       : 16'(RUN_DIV - 1);
    wire        sampleTick = (tickCount >= tickLimit);

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            tickCount <= 16'h0000;
        end else begin
            tickCount <= sampleTick ? 16'h0000 : tickCount + 16'h0001;
        end
    end

    // ------------------------------------------------------------------------
    // Per-pin input path
    // ------------------------------------------------------------------------
    for (genvar i = 0; i < 16; i++) begin : g_pin
        ghlt_pin_sync u_sync (
            .mclk       (mclk),
            .resetn     (resetn),
            .pinLevel   (pinIn[i]),
            .sampleTick (sampleTick),
            .syncLevel  (syncLevel[i]),
            .riseEvt    (riseEvt[i]),
            .fallEvt    (fallEvt[i])
        );
    end

    // ------------------------------------------------------------------------
    // Hotkey qualification and events
    // ------------------------------------------------------------------------
    ghlt_pins_t funcPrimary;
    for (genvar i = 0; i < 16; i++) begin : g_func
        assign funcPrimary[i] = funcSel[2*i+1 -: 2] == `GHLT_FUNC_PRIMARY;
    end

    // Edge detection stays live on translating pins as well.
    wire [15:0] edgeSet = (riseEvt & riseEn) | (fallEvt & fallEn);
    wire [15:0] hotQual = funcPrimary & ~dirReg & pinIrqMask
                        & {16{globalIrqEn}};
    wire        wakeEvt = |(edgeSet & hotQual);

    // ------------------------------------------------------------------------
    // Level translator drive
    // ------------------------------------------------------------------------
    ghlt_pins_t nextOut;
    ghlt_pins_t nextOe;
    for (genvar i = 0; i < 8; i++) begin : g_lt
        // Direction 0 carries the low pin to the high pin, 1 the reverse.
        assign nextOut[i]   = ltEn[i] ? syncLevel[i+8] : outState[i];
        assign nextOut[i+8] = ltEn[i] ? syncLevel[i]   : outState[i+8];
        assign nextOe[i]    = ltEn[i] ? ltDir[i]       : dirReg[i];
        assign nextOe[i+8]  = ltEn[i] ? ~ltDir[i]      : dirReg[i+8];
    end

    // ------------------------------------------------------------------------
    // Pin state and direction; translating pairs ignore these writes.
    // ------------------------------------------------------------------------
    wire [15:0] dirWrite = {wrDirHi ? 8'hff : 8'h00, wrDirLo ? 8'hff : 8'h00} & ~ltLock;
    wire [15:0] dirData  = {regWrData, regWrData};

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            outState <= `GHLT_RST_PINS;
            dirReg   <= `GHLT_RST_PINS;
        end else begin
            outState <= (outState | (setMask & ~ltLock)) & ~(clrMask & ~ltLock);
            dirReg   <= (dirReg & ~dirWrite) | (dirData & dirWrite);
        end
    end

    // Edge status: a new edge in the clearing cycle survives the clear.
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            edgeStatus <= `GHLT_RST_PINS;
        end else begin
            edgeStatus <= (edgeStatus & ~edsMask) | edgeSet;
        end
    end

    // ------------------------------------------------------------------------
    // Plain configuration registers
    // ------------------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            riseEn      <= `GHLT_RST_PINS;
            fallEn      <= `GHLT_RST_PINS;
            pullUpEn    <= `GHLT_RST_PINS;
            pinIrqMask  <= `GHLT_RST_PINS;
            ltEn        <= `GHLT_RST_BYTE;
            ltDir       <= `GHLT_RST_BYTE;
            globalIrqEn <= 1'b0;
        end else begin
            if (wrRiseHi) riseEn[15:8]     <= regWrData;
            if (wrRiseLo) riseEn[7:0]      <= regWrData;
            if (wrFallHi) fallEn[15:8]     <= regWrData;
            if (wrFallLo) fallEn[7:0]      <= regWrData;
            if (wrPullHi) pullUpEn[15:8]   <= regWrData;
            if (wrPullLo) pullUpEn[7:0]    <= regWrData;
            if (wrMskHi)  pinIrqMask[15:8] <= regWrData;
            if (wrMskLo)  pinIrqMask[7:0]  <= regWrData;
            if (wrLtEn)   ltEn             <= regWrData;
            if (wrLtDir)  ltDir            <= regWrData;
            if (wrSys)    globalIrqEn      <= regWrData[`GHLT_SYS_GIE_BIT];
        end
    end

    // Function select words; each byte holds four 2-bit fields.
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            funcSel <= `GHLT_RST_FUNC;
        end else begin
            if (wrAfuHi) funcSel[31:24] <= regWrData;
            if (wrAfuLo) funcSel[23:16] <= regWrData;
            if (wrAflHi) funcSel[15:8]  <= regWrData;
            if (wrAflLo) funcSel[7:0]   <= regWrData;
        end
    end

    // ------------------------------------------------------------------------
    // Power mode; the host is trusted to arm hotkeys before asking for sleep.
    // ------------------------------------------------------------------------
    wire sleepReq = wrSys && regWrData[`GHLT_SYS_SLEEP_BIT];
    wire runReq   = wrSys && !regWrData[`GHLT_SYS_SLEEP_BIT];

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            modeState <= GHLT_RUN;
            wakeUp    <= 1'b0;
        end else begin
            wakeUp <= 1'b0;
            case (modeState)
                GHLT_RUN: begin
                    if (sleepReq) begin
                        modeState <= GHLT_SLEEP;
                    end
                end
                GHLT_SLEEP: begin
                    // A hotkey wins over a same-cycle write that keeps sleep.
                    if (wakeEvt) begin
                        modeState <= GHLT_RUN;
                        wakeUp    <= 1'b1;
                    end else if (runReq) begin
                        modeState <= GHLT_RUN;
                    end
                end
                default: modeState <= GHLT_RUN;
            endcase
        end
    end

    // ------------------------------------------------------------------------
    // Registered pin outputs and interrupt requests
    // ------------------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            pinOut    <= `GHLT_RST_PINS;
            pinOe     <= `GHLT_RST_PINS;
            gpioIrq   <= `GHLT_RST_PINS;
            sleepMode <= 1'b0;
        end else begin
            pinOut    <= nextOut;
            pinOe     <= nextOe;
            gpioIrq   <= edgeStatus & pinIrqMask & {16{globalIrqEn}};
            sleepMode <= (modeState == GHLT_SLEEP);
        end
    end

    // ------------------------------------------------------------------------
    // Read mux; set and clear are write-only and unmapped addresses read zero.
    // ------------------------------------------------------------------------
    wire [7:0] sysRead = 8'({globalIrqEn, modeState == GHLT_SLEEP});
    wire [7:0] rdMux =
        regAddr == `GHLT_OFS_MON_MSB  ? syncLevel[15:8] :
        regAddr == `GHLT_OFS_MON_LSB  ? syncLevel[7:0]  :
        regAddr == `GHLT_OFS_DIR_MSB  ? dirReg[15:8]    :
        regAddr == `GHLT_OFS_DIR_LSB  ? dirReg[7:0]     :
        regAddr == `GHLT_OFS_EDS_MSB  ? edgeStatus[15:8] :
        regAddr == `GHLT_OFS_EDS_LSB  ? edgeStatus[7:0] :
        regAddr == `GHLT_OFS_RISE_MSB ? riseEn[15:8]    :
        regAddr == `GHLT_OFS_RISE_LSB ? riseEn[7:0]     :
        regAddr == `GHLT_OFS_FALL_MSB ? fallEn[15:8]    :
        regAddr == `GHLT_OFS_FALL_LSB ? fallEn[7:0]     :
        regAddr == `GHLT_OFS_PULL_MSB ? pullUpEn[15:8]  :
        regAddr == `GHLT_OFS_PULL_LSB ? pullUpEn[7:0]   :
        regAddr == `GHLT_OFS_AFU_MSB  ? funcSel[31:24]  :
        regAddr == `GHLT_OFS_AFU_LSB  ? funcSel[23:16]  :
        regAddr == `GHLT_OFS_AFL_MSB  ? funcSel[15:8]   :
        regAddr == `GHLT_OFS_AFL_LSB  ? funcSel[7:0]    :
        regAddr == `GHLT_OFS_LT_EN    ? ltEn            :
        regAddr == `GHLT_OFS_LT_DIR   ? ltDir           :
        regAddr == `GHLT_OFS_SYS_CTRL ? sysRead         :
        regAddr == `GHLT_OFS_IMSK_MSB ? pinIrqMask[15:8] :
        regAddr == `GHLT_OFS_IMSK_LSB ? pinIrqMask[7:0] :
        8'h00;

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            regRdData <= 8'h00;
        end else if (regRead) begin
            regRdData <= rdMux;
        end
    end

endmodule

// ===== sim/ghlt_pin_model.sv
// Pin-side model: outside drivers, pull-ups and floating pins around the port.
// Assumes the bench moves extDrive and extLevel only at falling clock edges.
module ghlt_pin_model (
    input  wire logic        mclk,
    input  wire logic [15:0] pinOut,
    input  wire logic [15:0] pinOe,
    input  wire logic [15:0] pullUpEn,
    input  wire logic [15:0] extDrive,
    input  wire logic [15:0] extLevel,
    output logic      [15:0] pinIn
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] floatLvl = 16'h0000;

    // A floating pin flips every cycle, so nothing may lean on a stale level.
    always @(posedge mclk) begin
        floatLvl <= ~floatLvl;
    end

    // Device drive wins, then the outside driver, then the pull-up.
    assign pinIn = (pinOe & pinOut) | (~pinOe & extDrive & extLevel)
                 | (~pinOe & ~extDrive & (pullUpEn | floatLvl));
endmodule

// ===== sim/ghlt_gpio_props.sv
// Port checker for the GPIO hotkey and level translator block.
// Assumes a single mclk domain with synchronous active-low resetn.
module ghlt_gpio_props
    import ghlt_pkg::*;
(
    input wire logic        mclk,
    input wire logic        resetn,
    input wire logic [7:0]  regAddr,
    input wire logic [7:0]  regWrData,
    input wire logic        regWrite,
    input wire logic        regRead,
    input wire logic [7:0]  regRdData,
    input wire logic [15:0] pinIn,
    input wire logic [15:0] pinOe,
    input wire logic [31:0] funcSel,
    input wire logic [15:0] gpioIrq,
    input wire logic        wakeUp,
    input wire logic        sleepMode
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);

    // ------------------------------------------------------------------
    // Sequences and properties
    // ------------------------------------------------------------------
    sequence pinsQuiet;
        $stable(pinIn[7:0]) [*4];
    endsequence
    sequence leaveSleep;
        sleepMode ##1 !sleepMode ##[0:1] (gpioIrq != 16'h0000);
    endsequence
    property funcWrite(logic [7:0] a, int lo);
        (regWrite && regAddr == a) |=> (funcSel[lo +: 8] == $past(regWrData));
    endproperty

    // Pins come out of reset as inputs, in run mode, primary function.
    reset_clear_a: assert property ($rose(resetn) |-> pinOe == 16'h0000 && !sleepMode
        && funcSel == 32'h0) else $error("outputs not clear after reset");
    func_upper_a: assert property (funcWrite(8'h12, 24))
        else $error("upper function byte not stored");
    func_lower_a: assert property (funcWrite(8'h15, 0))
        else $error("lower function byte not stored");
    // Drive enables only move as a consequence of a register write.
    oe_cause_a: assert property ($changed(pinOe) |-> $past(regWrite) || $past(regWrite, 2)
        || $past(regWrite, 3)) else $error("pin enable changed without a write");
    sleep_entry_a: assert property ($rose(sleepMode) |-> $past(regWrite)
        || $past(regWrite, 2) || $past(regWrite, 3)) else $error("sleep without request");
    wake_exit_a: assert property (wakeUp |-> leaveSleep)
        else $error("wake pulse without leaving sleep and interrupt");
    // A pending interrupt only drops after a register write.
    irq_holds_a: assert property (gpioIrq != 16'h0000 && !regWrite && !$past(regWrite)
        |=> gpioIrq != 16'h0000) else $error("interrupt dropped by itself");
    mon_read_a: assert property (pinsQuiet ##0 (regRead && regAddr == 8'h07)
        |=> regRdData == $past(pinIn[7:0])) else $error("monitor read differs from pins");
endmodule

bind ghlt_gpio_top ghlt_gpio_props i_ghlt_gpio_props (.mclk(mclk), .resetn(resetn),
    .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
    .regRdData(regRdData), .pinIn(pinIn), .pinOe(pinOe), .funcSel(funcSel),
    .gpioIrq(gpioIrq), .wakeUp(wakeUp), .sleepMode(sleepMode));

// ===== sim/ghlt_gpio_top_bench.sv
// Self-checking bench for the GPIO hotkey and level translator block.
// Assumes the pin model closes the pin loop and the checker is bound.
module ghlt_gpio_top_bench;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct { logic [7:0] a; logic [7:0] d; logic [7:0] e; } ghlt_row_t;
    logic mclk = 1'b0, resetn = 1'b0, regWrite = 1'b0, regRead = 1'b0, wakeUp, sleepMode;
    logic [7:0]  regAddr = 8'h00, regWrData = 8'h00, regRdData, rv;
    logic [15:0] pinIn, pinOut, pinOe, pullUpEn, gpioIrq;
    logic [15:0] extDrive = 16'h0000, extLevel = 16'h0000;
    logic [31:0] funcSel;
    int nFail = 0, numChecks = 0, cycles = 0;
    logic woke;
    // Readback rows: address, written byte, expected read; 0x30 is unmapped.
    ghlt_row_t rows [12] = '{'{8'h12, 8'he4, 8'he4}, '{8'h13, 8'h1b, 8'h1b},
        '{8'h14, 8'h39, 8'h39}, '{8'h15, 8'h31, 8'h31}, '{8'h0e, 8'h3c, 8'h3c},
        '{8'h10, 8'hf0, 8'hf0}, '{8'h11, 8'hf6, 8'hf6}, '{8'h21, 8'ha5, 8'ha5},
        '{8'h22, 8'h5a, 8'h5a},
        '{8'h17, 8'h81, 8'h81}, '{8'h02, 8'h00, 8'h00}, '{8'h30, 8'h55, 8'h00}};

    ghlt_gpio_top i_ghlt_gpio_top (.mclk(mclk), .resetn(resetn), .regAddr(regAddr),
        .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
        .pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe), .pullUpEn(pullUpEn),
        .funcSel(funcSel), .gpioIrq(gpioIrq), .wakeUp(wakeUp), .sleepMode(sleepMode));
    ghlt_pin_model i_ghlt_pin_model (.mclk(mclk), .pinOut(pinOut), .pinOe(pinOe),
        .pullUpEn(pullUpEn), .extDrive(extDrive), .extLevel(extLevel), .pinIn(pinIn));

    // ------------------------------------------------------------------
    // Clock, watchdog and shared tasks
    // ------------------------------------------------------------------
    initial begin
        forever #20 mclk = ~mclk;
    end
    // The run needs under 10000 cycles; a hang is cut off well after that.
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 20000) begin
            nFail++;
            summarize();
        end
    end
    task automatic summarize();
        $display("checks %0d, mismatches %0d", numChecks, nFail);
        if (nFail == 0 && numChecks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        numChecks++;
        if (got !== exp) begin
            nFail++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge mclk);
        regAddr = a;
        regWrData = d;
        regWrite = 1'b1;
        @(negedge mclk);
        regWrite = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge mclk);
        regAddr = a;
        regRead = 1'b1;
        @(negedge mclk);
        regRead = 1'b0;
        @(negedge mclk);
        d = regRdData;
    endtask

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        repeat (20) @(negedge mclk);
        resetn = 1'b1;
        chk({pinOe, funcSel[15:0]}, 32'h0);
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].d);
            rd(rows[i].a, rv);
            chk(rv, rows[i].e);
        end
        chk(funcSel, 32'he41b3931);
        chk(funcSel[7:0], 8'h31);
        chk(pullUpEn, 16'hf0f6);
        wr(8'h0e, 8'h00); wr(8'h21, 8'h00); wr(8'h22, 8'h00); wr(8'h17, 8'h00);
        wr(8'h0a, 8'hff); wr(8'h0b, 8'hff);
        // Plain pin 0 output: set, a zero write, then clear.
        wr(8'h09, 8'h01); wr(8'h03, 8'h01); wr(8'h03, 8'h00); repeat (3) @(negedge mclk);
        chk({pinOe[0], pinOut[0]}, 2'b11);
        wr(8'h05, 8'h01); repeat (3) @(negedge mclk);
        chk(pinOut[0], 1'b0);
        // Translator pair 1/9, first from pin 1 to pin 9, then reversed.
        extDrive = 16'h0002; extLevel = 16'h0002;
        wr(8'h16, 8'h02); repeat (6) @(negedge mclk);
        chk({pinOe[9], pinOut[9]}, 2'b11);
        extDrive = 16'h0200; extLevel = 16'h0000;
        wr(8'h17, 8'h02); wr(8'h0c, 8'h02); repeat (6) @(negedge mclk);
        chk({pinOe[1], pinOe[9], pinOut[1]}, 3'b100);
        extLevel = 16'h0200; repeat (12) @(negedge mclk);
        chk(pinOut[1], 1'b1);
        rd(8'h0a, rv);
        chk(rv[1], 1'b1);
        wr(8'h05, 8'h02); wr(8'h03, 8'h02); wr(8'h08, 8'h02); repeat (3) @(negedge mclk);
        chk({pinOut[1], pinOe[9]}, 2'b10);
        // Once the pair is released the locked set and direction writes must not show.
        wr(8'h0c, 8'h00); wr(8'h16, 8'h00); repeat (3) @(negedge mclk);
        chk({pinOut[1], pinOe[9]}, 2'b00);
        wr(8'h08, 8'h00); wr(8'h0a, 8'hff);
        // Hotkey on pin 3: without its pin mask nothing may wake the device.
        // The low level must be sampled in run mode before the rise counts as an edge.
        extDrive = 16'h0008; extLevel = 16'h0000; repeat (12) @(negedge mclk);
        wr(8'h0d, 8'h08); wr(8'h0b, 8'hff); wr(8'h20, 8'h03); repeat (4) @(negedge mclk);
        chk(sleepMode, 1'b1);
        extLevel = 16'h0008; repeat (800) @(negedge mclk);
        rd(8'h07, rv);
        chk(rv, 8'hfe);
        repeat (800) @(negedge mclk);
        extLevel = 16'h0000;
        chk(sleepMode, 1'b1);
        rd(8'h0b, rv);
        chk(rv[3], 1'b1);
        // Hold the release as long as an assertion, so the sleep sampler sees it.
        repeat (1600) @(negedge mclk);
        wr(8'h0b, 8'h08); wr(8'h22, 8'h08); repeat (4) @(negedge mclk);
        woke = 1'b0;
        extLevel = 16'h0008;
        for (int i = 0; i < 2000 && woke !== 1'b1; i++) begin
            @(negedge mclk);
            woke = wakeUp;
        end
        chk(woke, 1'b1);
        repeat (2) @(negedge mclk);
        chk({gpioIrq[3], sleepMode}, 2'b10);
        repeat (1600) @(negedge mclk);
        extLevel = 16'h0000;
        wr(8'h0b, 8'h00); repeat (3) @(negedge mclk);
        chk(gpioIrq[3], 1'b1);
        wr(8'h0b, 8'h08); repeat (3) @(negedge mclk);
        chk(gpioIrq, 16'h0000);
        // A second edge in run mode interrupts without any sleep involved.
        extLevel = 16'h0008; repeat (20) @(negedge mclk);
        chk(gpioIrq, 16'h0008);
        summarize();
    end
endmodule
